// *** src/pcl_map.vh ***
// Constants for the parallel configuration loader
`ifndef PCL_MAP_VH
`define PCL_MAP_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define PCL_CLK_MHZ          100
`define PCL_T_CF2LOW_NS      600
`define PCL_CF2LOW_CYC       ((`PCL_T_CF2LOW_NS * `PCL_CLK_MHZ) / 1000)
`define PCL_T_STATUS_MIN_US  268
`define PCL_T_STATUS_MAX_US  1506
`define PCL_STATUS_MIN_CYC   (`PCL_T_STATUS_MIN_US * `PCL_CLK_MHZ)
`define PCL_STATUS_MAX_CYC   (`PCL_T_STATUS_MAX_US * `PCL_CLK_MHZ)
`define PCL_T_UM_MIN_US      175
`define PCL_T_UM_MAX_US      437
`define PCL_UM_MIN_CYC       (`PCL_T_UM_MIN_US * `PCL_CLK_MHZ)
`define PCL_UM_MAX_CYC       (`PCL_T_UM_MAX_US * `PCL_CLK_MHZ)
`define PCL_USR_INIT_CYCLES  8576
`define PCL_OSC_DIV          8

// ****************************************************************
// Widths and encodings
// ****************************************************************
`define PCL_CNT_W            18
`define PCL_DATA_W           32
`define PCL_FIFO_DEPTH       4
`define PCL_RATIO_W          4
`define PCL_WIDTH_X8         2'h0
`define PCL_WIDTH_X16        2'h1
`define PCL_WIDTH_X32        2'h2

`endif

// *** src/pcl_fifo.v ***
// Small valid/ready FIFO with registered read data
`timescale 1ns/1ps

module pcl_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk_sys_i,
    input  wire             rst_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output reg              out_valid_o,
    input  wire             out_ready_i,
    output reg  [WIDTH-1:0] out_data_o
);
    reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_ff;
    reg  [AW-1:0]    rd_ptr_ff;
    reg  [AW:0]      count_ff;
    wire             push;
    wire             pop;
    wire             load_out;

    assign in_ready_o = (count_ff != DEPTH[AW:0]);
    assign push       = in_valid_i & in_ready_o;
    // Output register refills when the FIFO holds data and the register is empty or being taken
    assign load_out   = (count_ff != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);
    assign pop        = load_out;

    always @(posedge clk_sys_i)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data_i;
    end

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ptr_ff   <= {AW{1'b0}};
            rd_ptr_ff   <= {AW{1'b0}};
            count_ff    <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
            if (load_out)
            begin
                out_data_o  <= mem_ff[rd_ptr_ff];
                out_valid_o <= 1'b1;
            end
            else if (out_ready_i)
                out_valid_o <= 1'b0;
        end
    end
endmodule // pcl_fifo

// *** src/pcl_loader.v ***
// Fast parallel configuration load port, device end
// Behaviour
// - Extra config_clock cycles per word are spent decrypting and decompressing; here they only advance the ratio phase.
// - Done goes low within 600 ns of request falling.
// - Status goes low within 600 ns of request falling.
// - Status held low between 268 and 1506 us during reset.
// - Status released by 1506 us after request rises, unless extended.
// - Internal oscillator: user mode 175 to 437 us after done rises.
// - With user_init_clock, user mode after enable plus 8576 of its periods.
`timescale 1ns/1ps
`include "pcl_map.vh"

module pcl_loader #(
    parameter STATUS_CYC = `PCL_STATUS_MIN_CYC,
    parameter UM_CYC     = `PCL_UM_MIN_CYC
) (
    input  wire                    clk_sys_i,
    input  wire                    rst_n_i,
    input  wire                    config_req_n_i,
    input  wire                    config_clock_i,
    input  wire [`PCL_DATA_W-1:0]  data_i,
    input  wire [1:0]              width_sel_i,
    input  wire [`PCL_RATIO_W-1:0] ratio_i,
    input  wire [31:0]             image_words_i,
    input  wire                    status_n_i,
    input  wire                    user_init_clock_i,
    input  wire                    use_user_clock_i,
    output reg                     status_n_o,
    output reg                     status_n_oe_n_o,
    output reg                     done_o,
    output reg                     user_mode_o,
    output reg                     word_valid_o,
    output reg  [`PCL_DATA_W-1:0]  word_data_o,
    input  wire                    word_ready_i,
    output reg                     overflow_o
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_RESET = 3'h1;
    localparam ST_LOAD  = 3'h2;
    localparam ST_INIT  = 3'h3;
    localparam ST_USER  = 3'h4;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg  [1:0] req_sync_ff;
    reg  [1:0] clk_sync_ff;
    reg  [1:0] stat_sync_ff;
    reg  [1:0] uclk_sync_ff;
    reg  [`PCL_DATA_W-1:0] data_s1_ff;
    reg  [`PCL_DATA_W-1:0] data_s2_ff;
    reg        clk_prev_ff;
    reg        uclk_prev_ff;

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_sync_ff  <= 2'h3;
            clk_sync_ff  <= 2'h0;
            stat_sync_ff <= 2'h3;
            uclk_sync_ff <= 2'h0;
            data_s1_ff   <= {`PCL_DATA_W{1'b0}};
            data_s2_ff   <= {`PCL_DATA_W{1'b0}};
            clk_prev_ff  <= 1'b0;
            uclk_prev_ff <= 1'b0;
        end
        else
        begin
            req_sync_ff  <= {req_sync_ff[0], config_req_n_i};
            clk_sync_ff  <= {clk_sync_ff[0], config_clock_i};
            stat_sync_ff <= {stat_sync_ff[0], status_n_i};
            uclk_sync_ff <= {uclk_sync_ff[0], user_init_clock_i};
            data_s1_ff   <= data_i;
            data_s2_ff   <= data_s1_ff;
            clk_prev_ff  <= clk_sync_ff[1];
            uclk_prev_ff <= uclk_sync_ff[1];
        end
    end

    wire req_low   = ~req_sync_ff[1];
    wire clk_rise  = clk_sync_ff[1] & ~clk_prev_ff;
    wire uclk_rise = uclk_sync_ff[1] & ~uclk_prev_ff;
    // Wired status pulled low by another party counts as extension
    wire stat_ext  = ~stat_sync_ff[1];

    // ************************************************************
    // Word capture, width masking, ratio phase
    // ************************************************************
    reg  [`PCL_DATA_W-1:0] masked_data;

    always @*
    begin
        case (width_sel_i)
            `PCL_WIDTH_X8:  masked_data = {24'h000000, data_s2_ff[7:0]};
            `PCL_WIDTH_X16: masked_data = {16'h0000, data_s2_ff[15:0]};
            default:        masked_data = data_s2_ff;
        endcase
    end

    reg  [2:0]              state_ff;
    reg  [2:0]              nxt_state;
    reg  [`PCL_CNT_W-1:0]   cnt_ff;
    reg  [`PCL_CNT_W-1:0]   nxt_cnt;
    reg  [`PCL_RATIO_W-1:0] phase_ff;
    reg  [31:0]             words_ff;
    reg                     flush_ff;

    wire [`PCL_RATIO_W-1:0] ratio_eff = (ratio_i == {`PCL_RATIO_W{1'b0}}) ?
                                        {{(`PCL_RATIO_W-1){1'b0}}, 1'b1} : ratio_i;
    // Only the first edge of each ratio group latches; the rest only advance the ratio phase
    wire latch_edge = (state_ff == ST_LOAD) & clk_rise
                      & (phase_ff == {`PCL_RATIO_W{1'b0}}) & ~flush_ff;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`PCL_DATA_W-1:0] fifo_out_data;

    pcl_fifo #(
        .WIDTH (`PCL_DATA_W),
        .DEPTH (`PCL_FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (latch_edge),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (masked_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (~word_valid_o | word_ready_i),
        .out_data_o  (fifo_out_data)
    );

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_ff <= {`PCL_RATIO_W{1'b0}};
            words_ff <= 32'h00000000;
            flush_ff <= 1'b0;
        end
        else if (state_ff != ST_LOAD)
        begin
            phase_ff <= {`PCL_RATIO_W{1'b0}};
            words_ff <= 32'h00000000;
            flush_ff <= 1'b0;
        end
        else if (clk_rise)
        begin
            if (phase_ff == ratio_eff - 1'b1)
                phase_ff <= {`PCL_RATIO_W{1'b0}};
            else
                phase_ff <= phase_ff + 1'b1;
            if (latch_edge)
            begin
                words_ff <= words_ff + 32'h00000001;
                if (words_ff + 32'h00000001 == image_words_i)
                    flush_ff <= 1'b1;
            end
        end
    end

    // Last word seen and ratio-1 trailing edges consumed
    wire load_end = flush_ff & (phase_ff == {`PCL_RATIO_W{1'b0}});

    // ************************************************************
    // Status drive
    // ************************************************************
    // Must let go after the count, or our own pull-down would look like
    // an external extension and the reset phase would never end
    reg stat_drive;

    always @*
    begin
        stat_drive = (nxt_state == ST_IDLE);
        // Count done: pull-up or another party now sets the level
        if (nxt_state == ST_RESET)
            stat_drive = (nxt_cnt < STATUS_CYC[`PCL_CNT_W-1:0]);
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always @*
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_cnt = {`PCL_CNT_W{1'b0}};
            end
            ST_RESET:
            begin
                // Reset count runs only while the request is back high
                if (req_low)
                begin
                    nxt_cnt = {`PCL_CNT_W{1'b0}};
                end
                else if (cnt_ff < STATUS_CYC[`PCL_CNT_W-1:0])
                    nxt_cnt = cnt_ff + 1'b1;
                else if (!stat_ext)
                begin
                    // Own drive is off by now, so a low line is an extension
                    nxt_state = ST_LOAD;
                    nxt_cnt   = {`PCL_CNT_W{1'b0}};
                end
            end
            ST_LOAD:
            begin
                if (load_end)
                begin
                    nxt_state = ST_INIT;
                    nxt_cnt   = {`PCL_CNT_W{1'b0}};
                end
            end
            ST_INIT:
            begin
                if (use_user_clock_i)
                begin
                    if (uclk_rise)
                        nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == `PCL_USR_INIT_CYCLES)
                        nxt_state = ST_USER;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff >= UM_CYC[`PCL_CNT_W-1:0] - 1'b1)
                        nxt_state = ST_USER;
                end
            end
            ST_USER:
            begin
                nxt_cnt = {`PCL_CNT_W{1'b0}};
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_cnt   = {`PCL_CNT_W{1'b0}};
            end
        endcase
        // Request low restarts from any state, well inside 600 ns
        if (req_low && state_ff != ST_RESET)
        begin
            nxt_state = ST_RESET;
            nxt_cnt   = {`PCL_CNT_W{1'b0}};
        end
        else if (state_ff == ST_IDLE && !req_low)
            nxt_state = ST_RESET;
    end

    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff        <= ST_IDLE;
            cnt_ff          <= {`PCL_CNT_W{1'b0}};
            status_n_o      <= 1'b0;
            status_n_oe_n_o <= 1'b0;
            done_o          <= 1'b0;
            user_mode_o     <= 1'b0;
            word_valid_o    <= 1'b0;
            word_data_o     <= {`PCL_DATA_W{1'b0}};
            overflow_o      <= 1'b0;
        end
        else
        begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            status_n_o  <= 1'b0;
            // Open drain: low enable pulls the pin low
            status_n_oe_n_o <= ~stat_drive;
            done_o      <= (nxt_state == ST_INIT) | (nxt_state == ST_USER);
            user_mode_o <= (nxt_state == ST_USER);
            if (fifo_out_valid & (~word_valid_o | word_ready_i))
            begin
                word_valid_o <= 1'b1;
                word_data_o  <= fifo_out_data;
            end
            else if (word_ready_i)
                word_valid_o <= 1'b0;
            // Lost word: FIFO full at a latch edge; stays until next request
            if (latch_edge & ~fifo_in_ready)
                overflow_o <= 1'b1;
            else if (nxt_state == ST_RESET)
                overflow_o <= 1'b0;
        end
    end
endmodule // pcl_loader

// *** sim/pcl_loader_assertions.sv ***
// Port checker for the parallel configuration loader
`timescale 1ns/1ps
`include "pcl_map.vh"

module pcl_loader_assertions #(
    parameter STATUS_CYC = 50,
    parameter UM_CYC     = 40
) (
    input wire                   clk_sys_i,
    input wire                   rst_n_i,
    input wire                   config_req_n_i,
    input wire [1:0]             width_sel_i,
    input wire                   user_init_clock_i,
    input wire                   use_user_clock_i,
    input wire                   status_n_oe_n_o,
    input wire                   done_o,
    input wire                   user_mode_o,
    input wire                   word_valid_o,
    input wire [`PCL_DATA_W-1:0] word_data_o,
    input wire                   word_ready_i
);
    localparam int USR_LO = 8574;
    localparam int USR_HI = 8580;
    int         low_ff;
    int         reqhi_ff;
    int         done_ff;
    int         uclk_ff;
    logic [1:0] usync_ff;

    // Counters in place of long repetitions
    always @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            low_ff   <= 0;
            reqhi_ff <= 0;
            done_ff  <= 0;
            uclk_ff  <= 0;
            usync_ff <= 2'h0;
        end
        else
        begin
            low_ff   <= status_n_oe_n_o ? 0 : low_ff + 1;
            reqhi_ff <= (status_n_oe_n_o || !config_req_n_i) ? 0 : reqhi_ff + 1;
            done_ff  <= done_o ? done_ff + 1 : 0;
            usync_ff <= {usync_ff[0], user_init_clock_i};
            uclk_ff  <= !done_o ? 0 : uclk_ff + (usync_ff[0] & ~usync_ff[1]);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_done_drop: assert property ($fell(config_req_n_i) |-> ##[1:60] !done_o)
        else $error("done not low in time");
    a_status_drop: assert property ($fell(config_req_n_i) |-> ##[1:60] !status_n_oe_n_o)
        else $error("status not low in time");
    a_mode_clear: assert property ($fell(config_req_n_i) |-> ##[1:60] !user_mode_o)
        else $error("user mode kept after request");
    a_status_min: assert property ($rose(status_n_oe_n_o) |-> low_ff >= STATUS_CYC)
        else $error("status low too short");
    a_status_release: assert property (reqhi_ff <= STATUS_CYC + 10)
        else $error("status released late");
    a_um_internal: assert property ($rose(user_mode_o) && !use_user_clock_i
        |-> done_ff >= UM_CYC - 1 && done_ff <= UM_CYC + 8)
        else $error("internal init delay wrong");
    a_um_user: assert property ($rose(user_mode_o) && use_user_clock_i
        |-> uclk_ff >= USR_LO && uclk_ff <= USR_HI)
        else $error("user clock init count wrong");
    a_word_hold: assert property (word_valid_o && !word_ready_i
        |=> word_valid_o && $stable(word_data_o))
        else $error("word dropped while stalled");
    a_mask_narrow: assert property (word_valid_o && width_sel_i != `PCL_WIDTH_X32
        |-> word_data_o[31:16] == 16'h0)
        else $error("unused data lines not masked");

    c_done: cover property ($rose(done_o));
    c_user: cover property ($rose(user_mode_o) && use_user_clock_i);
    c_stall: cover property (word_valid_o && !word_ready_i);
endmodule // pcl_loader_assertions

bind pcl_loader pcl_loader_assertions #(.STATUS_CYC(STATUS_CYC), .UM_CYC(UM_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .config_req_n_i(config_req_n_i),
    .width_sel_i(width_sel_i), .user_init_clock_i(user_init_clock_i),
    .use_user_clock_i(use_user_clock_i), .status_n_oe_n_o(status_n_oe_n_o),
    .done_o(done_o), .user_mode_o(user_mode_o), .word_valid_o(word_valid_o),
    .word_data_o(word_data_o), .word_ready_i(word_ready_i));

// *** sim/pcl_host.sv ***
// Configuration host model driving the parallel load pins
`timescale 1ns/1ps

module pcl_host (
    input  wire        clk_sys_i,
    input  wire        start_i,
    input  wire [3:0]  ratio_i,
    input  wire [7:0]  words_i,
    input  wire        status_line_i,
    output reg         config_req_n_o,
    output reg         config_clock_o,
    output reg  [31:0] data_o,
    output reg         busy_o
);
    logic [31:0] sent_q[$];
    int          n;
    int          k;

    // 160 ns period, well under the width limits
    task automatic edge_pulse;
        repeat (8) @(negedge clk_sys_i);
        config_clock_o = 1'h1;
        repeat (8) @(negedge clk_sys_i);
        config_clock_o = 1'h0;
    endtask

    initial
    begin
        config_req_n_o = 1'h1;
        config_clock_o = 1'h0;
        data_o         = 32'h0;
        busy_o         = 1'h0;
        forever
        begin
            @(negedge clk_sys_i);
            if (start_i)
            begin
                busy_o = 1'h1;
                n = (ratio_i == 4'h0) ? 1 : ratio_i;
                config_req_n_o = 1'h0;
                repeat (200) @(negedge clk_sys_i);
                config_req_n_o = 1'h1;
                k = 0;
                // Status is watched, so its shorter wait applies
                while (!status_line_i && k < 200000)
                begin
                    @(negedge clk_sys_i);
                    k++;
                end
                repeat (200) @(negedge clk_sys_i);
                for (int w = 0; w < words_i; w++)
                begin
                    data_o = $urandom;
                    sent_q.push_back(data_o);
                    repeat (n) edge_pulse();
                end
                repeat (n - 1) edge_pulse();
                // Released bus must not look like the last word
                data_o = ~data_o;
                busy_o = 1'h0;
            end
        end
    end
endmodule // pcl_host

// *** sim/pcl_loader_tb.sv ***
// Self-checking bench for the parallel configuration loader
`timescale 1ns/1ps
`include "pcl_map.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t got %0h exp %0h", $time, (a), (b)); end end

module pcl_loader_tb;
    localparam int SC = 50;
    localparam int UC = 40;
    reg        clk_sys_i = 1'h0;
    reg        rst_n_i = 1'h0;
    reg        start = 1'h0;
    reg        ready = 1'h1;
    reg        uclk = 1'h0;
    reg        use_u = 1'h0;
    reg        stall = 1'h0;
    reg        skip = 1'h0;
    reg [1:0]  wsel = 2'h0;
    reg [3:0]  ratio = 4'h1;
    reg [7:0]  nwords = 8'h1;
    reg [31:0] exp_w;
    wire       req_n, config_clock, st_n, st_oe_n, done, um, wv, ovf, busy;
    wire [31:0] data, wdata;
    // Pull-up on the wired status line
    wire       st_line = st_oe_n ? 1'h1 : st_n;
    int        fail_count = 0;
    int        checks = 0;

    always #5 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) ready <= stall ? 1'h0 : ($urandom % 4 != 0);

    pcl_loader #(.STATUS_CYC(SC), .UM_CYC(UC)) uut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .config_req_n_i(req_n),
        .config_clock_i(config_clock), .data_i(data), .width_sel_i(wsel), .ratio_i(ratio),
        .image_words_i({24'h0, nwords}), .status_n_i(st_line), .user_init_clock_i(uclk),
        .use_user_clock_i(use_u), .status_n_o(st_n), .status_n_oe_n_o(st_oe_n),
        .done_o(done), .user_mode_o(um), .word_valid_o(wv), .word_data_o(wdata),
        .word_ready_i(ready), .overflow_o(ovf));

    pcl_host host (
        .clk_sys_i(clk_sys_i), .start_i(start), .ratio_i(ratio), .words_i(nwords),
        .status_line_i(st_line), .config_req_n_o(req_n), .config_clock_o(config_clock),
        .data_o(data), .busy_o(busy));

    function automatic logic [31:0] msk(input logic [1:0] w);
        return (w == 2'h0) ? 32'hFF : (w == 2'h1) ? 32'hFFFF : 32'hFFFFFFFF;
    endfunction

    function automatic bit cond(input int w);
        case (w)
            0: return !busy;
            1: return done === 1'h1;
            3: return wv !== 1'h1;
            4: return req_n === 1'h0;
            default: return req_n === 1'h1;
        endcase
    endfunction

    task finish_test;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_until(input int w);
        int n;
        n = 0;
        while (!cond(w))
        begin
            @(negedge clk_sys_i);
            n++;
            if (n > 20000)
            begin
                fail_count++;
                $display("BAD %0t wait ran out", $time);
                finish_test();
            end
        end
    endtask

    // Model of the word stream: masked host data, in order
    always @(posedge clk_sys_i)
    begin
        if (rst_n_i && wv === 1'h1 && ready && !skip)
        begin
            exp_w = host.sent_q.pop_front() & msk(wsel);
            `CHK(wdata, exp_w)
        end
    end

    task automatic load(input int r, input int w, input int n);
        int k;
        ratio = r[3:0];
        wsel = w[1:0];
        nwords = n[7:0];
        start = 1'h1;
        wait_until(4);
        start = 1'h0;
        repeat (60) @(negedge clk_sys_i);
        `CHK(done, 1'h0)
        `CHK(st_line, 1'h0)
        `CHK({um, ovf}, 2'h0)
        wait_until(5);
        repeat (SC - 2) @(negedge clk_sys_i);
        `CHK(st_line, 1'h0)
        wait_until(1);
        k = 0;
        if (use_u)
        begin
            repeat (64) @(negedge clk_sys_i);
            repeat (8575)
            begin
                uclk = 1'h1;
                repeat (2) @(negedge clk_sys_i);
                uclk = 1'h0;
                repeat (2) @(negedge clk_sys_i);
            end
            `CHK(um, 1'h0)
            uclk = 1'h1;
            repeat (12) @(negedge clk_sys_i);
            `CHK(um, 1'h1)
            uclk = 1'h0;
        end
        else
        begin
            while (um !== 1'h1 && k < 100)
            begin
                @(negedge clk_sys_i);
                k++;
            end
            `CHK(k >= UC - 2 && k <= UC + 8, 1'h1)
        end
        wait_until(0);
        if (!skip)
            `CHK(host.sent_q.size(), 0)
    endtask

    initial
    begin
        int s;
        s = $urandom(73);
        repeat (8) @(negedge clk_sys_i);
        `CHK({st_oe_n, done, um, wv, ovf}, 5'h0)
        rst_n_i = 1'h1;
        for (int i = 0; i < 4; i++)
            load(1 << i, i % 3, 3 + i);
        // Stall the sink so the buffer fills and refuses
        stall = 1'h1;
        skip = 1'h1;
        load(2, 2, 8);
        `CHK(ovf, 1'h1)
        stall = 1'h0;
        repeat (20) @(negedge clk_sys_i);
        wait_until(3);
        host.sent_q.delete();
        skip = 1'h0;
        use_u = 1'h1;
        load(4, 1, 3);
        finish_test();
    end
endmodule // pcl_loader_tb
